// ### scr_pkg.sv
/*
  Constants for the SPI clock and reset control slice: register offsets,
  field positions, field widths, reset values and power mode codes.
  Assumes nothing of its surroundings; every other file refers to it.
*/
package scr_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on the APB bus)
  // ****************************************************************
  localparam logic [7:0] OFS_DIV_CFG = 8'h2c; // spi_clock_divider_config
  localparam logic [7:0] OFS_GATE_EN = 8'h30; // spi_clock_gate_enable
  localparam logic [7:0] OFS_RST_CTL = 8'h34; // spi_reset_control
  localparam int ADDR_W = 8;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int POS_BAUD_SEL = 16;
  localparam int POS_LOW_PHASE = 8;
  localparam int POS_HIGH_PHASE = 0;
  localparam int PHASE_W = 3;
  localparam int POS_DEEP_SLEEP_GATE = 16;
  localparam int POS_SLEEP_GATE = 8;
  localparam int POS_RUN_GATE = 0;
  localparam int POS_ENABLED_FLAG = 1;
  localparam int POS_SOFT_RESET = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_BIT = 1'b0;
  localparam logic [PHASE_W-1:0] RST_PHASE = 3'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic DEEP_SLEEP_GATE_VAL = 1'b0; // Fixed, read-only

  // ****************************************************************
  // Baud source and power modes
  // ****************************************************************
  localparam logic SRC_XTAL = 1'b0;
  localparam logic SRC_PLL = 1'b1;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP_SLEEP
  } scr_power_mode_t;

  typedef enum logic {
    PH_HIGH,
    PH_LOW
  } scr_phase_t;

endpackage

// ### scr_phase_divider.sv
/*
  Programmable phase divider for the PLL-derived SPI baud clock.
  Counts cycles of its own clock (the PLL clock in the real chip) and
  drives a level that is high for (high_phase + 1) and low for
  (low_phase + 1) cycles. Assumes the phase fields are stable registers.
*/
`timescale 1ns/1ps

module scr_phase_divider #(
  parameter int PHASE_W = scr_pkg::PHASE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Phase lengths minus one
  input wire logic [PHASE_W-1:0] high_phase,
  input wire logic [PHASE_W-1:0] low_phase,
  // Divided clock level
  output logic div_clk
);

  scr_pkg::scr_phase_t phase_r;
  scr_pkg::scr_phase_t phase_nxt;
  logic [PHASE_W-1:0] cnt_r;
  logic [PHASE_W-1:0] cnt_nxt;

  // ****************************************************************
  // Phase counter
  // ****************************************************************

  // New field values count at once, even mid-phase; the >= compare ends a phase already past the new length
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_r + PHASE_W'(1);
    case (phase_r)
      scr_pkg::PH_HIGH: begin
        if (cnt_r >= high_phase) begin
          phase_nxt = scr_pkg::PH_LOW;
          cnt_nxt = '0;
        end
      end
      scr_pkg::PH_LOW: begin
        if (cnt_r >= low_phase) begin
          phase_nxt = scr_pkg::PH_HIGH;
          cnt_nxt = '0;
        end
      end
      default: begin
        phase_nxt = scr_pkg::PH_HIGH;
        cnt_nxt = '0;
      end
    endcase
  end

  // Register phase and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= scr_pkg::PH_HIGH;
      cnt_r <= '0;
    end else if (ce) begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign div_clk = (phase_r == scr_pkg::PH_HIGH);

endmodule

// ### scr_clock_reset_ctrl.sv
/*
  SPI clock and reset control slice: three APB registers, baud source
  selection between crystal and divided PLL clock, per power mode gating
  and a software reset for the SPI core.
  Assumes an APB master on pclk, a power mode code from the power
  controller on pclk, and a crystal clock level arriving from a pin.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module scr_clock_reset_ctrl #(
  parameter int PHASE_W = scr_pkg::PHASE_W
) (
  // Clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources and power mode
  input wire logic xtal_clk_in,
  input wire logic [1:0] power_mode,
  // To the SPI core
  output logic spi_clk_out,
  output logic core_reset_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic baud_source_select_r, baud_source_select_nxt;
  logic [PHASE_W-1:0] divider_low_phase_r, divider_low_phase_nxt;
  logic [PHASE_W-1:0] divider_high_phase_r, divider_high_phase_nxt;
  logic sleep_gate_r, sleep_gate_nxt;
  logic run_gate_r, run_gate_nxt;
  logic core_soft_reset_r, core_soft_reset_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic xtal_meta_r, xtal_sync_r;
  logic src_active_r, src_active_nxt;
  logic gate_on_r, gate_on_nxt;
  logic spi_clk_r, spi_clk_nxt;
  logic core_reset_r, core_reset_nxt;
  logic div_clk;
  logic src_level;
  logic mode_gate;
  logic enabled_flag;
  logic wr_en;
  logic addr_hit;

  // ****************************************************************
  // PLL divider
  // ****************************************************************

  // Runs on pclk here; in silicon it counts 240 MHz PLL cycles
  scr_phase_divider #(
    .PHASE_W(PHASE_W)
  ) u_divider (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .high_phase(divider_high_phase_r),
    .low_phase(divider_low_phase_r),
    .div_clk(div_clk)
  );

  // ****************************************************************
  // Crystal clock synchroniser
  // ****************************************************************

  // Two flops before anything looks at the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_meta_r <= 1'b0;
      xtal_sync_r <= 1'b0;
    end else if (ce) begin
      xtal_meta_r <= xtal_clk_in;
      xtal_sync_r <= xtal_meta_r;
    end
  end

  // ****************************************************************
  // APB register access
  // ****************************************************************

  // Decode; each register is one aligned word
  always_comb begin
    addr_hit = (paddr == scr_pkg::OFS_DIV_CFG) || (paddr == scr_pkg::OFS_GATE_EN)
               || (paddr == scr_pkg::OFS_RST_CTL);
    // Write lands only at the edge where pready is seen high
    wr_en = psel && penable && pready_r && pwrite && addr_hit;
  end

  // One wait state: pready rises in the second access cycle
  always_comb begin
    pready_nxt = psel && penable && !pready_r;
    pslverr_nxt = psel && penable && !pready_r && !addr_hit;
    prdata_nxt = prdata_r;
    if (psel && penable && !pready_r) begin
      prdata_nxt = scr_pkg::RST_WORD; // Unused and unmapped read zero
      if (!pwrite) begin
        case (paddr)
          scr_pkg::OFS_DIV_CFG: begin
            prdata_nxt[scr_pkg::POS_BAUD_SEL] = baud_source_select_r;
            prdata_nxt[scr_pkg::POS_LOW_PHASE +: PHASE_W] = divider_low_phase_r;
            prdata_nxt[scr_pkg::POS_HIGH_PHASE +: PHASE_W] = divider_high_phase_r;
          end
          scr_pkg::OFS_GATE_EN: begin
            prdata_nxt[scr_pkg::POS_DEEP_SLEEP_GATE] = scr_pkg::DEEP_SLEEP_GATE_VAL;
            prdata_nxt[scr_pkg::POS_SLEEP_GATE] = sleep_gate_r;
            prdata_nxt[scr_pkg::POS_RUN_GATE] = run_gate_r;
          end
          scr_pkg::OFS_RST_CTL: begin
            prdata_nxt[scr_pkg::POS_ENABLED_FLAG] = enabled_flag;
            prdata_nxt[scr_pkg::POS_SOFT_RESET] = core_soft_reset_r;
          end
          default: begin
            prdata_nxt = scr_pkg::RST_WORD;
          end
        endcase
      end
    end
  end

  // Writable fields only; all other bits are not stored
  always_comb begin
    baud_source_select_nxt = baud_source_select_r;
    divider_low_phase_nxt = divider_low_phase_r;
    divider_high_phase_nxt = divider_high_phase_r;
    sleep_gate_nxt = sleep_gate_r;
    run_gate_nxt = run_gate_r;
    core_soft_reset_nxt = core_soft_reset_r;
    if (wr_en) begin
      case (paddr)
        scr_pkg::OFS_DIV_CFG: begin
          baud_source_select_nxt = pwdata[scr_pkg::POS_BAUD_SEL];
          divider_low_phase_nxt = pwdata[scr_pkg::POS_LOW_PHASE +: PHASE_W];
          divider_high_phase_nxt = pwdata[scr_pkg::POS_HIGH_PHASE +: PHASE_W];
        end
        scr_pkg::OFS_GATE_EN: begin
          sleep_gate_nxt = pwdata[scr_pkg::POS_SLEEP_GATE];
          run_gate_nxt = pwdata[scr_pkg::POS_RUN_GATE];
        end
        scr_pkg::OFS_RST_CTL: begin
          core_soft_reset_nxt = pwdata[scr_pkg::POS_SOFT_RESET];
        end
        default: begin
          core_soft_reset_nxt = core_soft_reset_r;
        end
      endcase
    end
  end

  // Register file and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_source_select_r <= scr_pkg::RST_BIT;
      divider_low_phase_r <= scr_pkg::RST_PHASE;
      divider_high_phase_r <= scr_pkg::RST_PHASE;
      sleep_gate_r <= scr_pkg::RST_BIT;
      run_gate_r <= scr_pkg::RST_BIT;
      core_soft_reset_r <= scr_pkg::RST_BIT;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= scr_pkg::RST_WORD;
    end else if (ce) begin
      baud_source_select_r <= baud_source_select_nxt;
      divider_low_phase_r <= divider_low_phase_nxt;
      divider_high_phase_r <= divider_high_phase_nxt;
      sleep_gate_r <= sleep_gate_nxt;
      run_gate_r <= run_gate_nxt;
      core_soft_reset_r <= core_soft_reset_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ****************************************************************
  // Mode gating and status
  // ****************************************************************

  // Deep sleep always gates off: its enable is a constant zero
  always_comb begin
    case (power_mode)
      scr_pkg::MODE_RUN: mode_gate = run_gate_r;
      scr_pkg::MODE_SLEEP: mode_gate = sleep_gate_r;
      scr_pkg::MODE_DEEP_SLEEP: mode_gate = scr_pkg::DEEP_SLEEP_GATE_VAL;
      default: mode_gate = 1'b0;
    endcase
    // Enabled means the clock is running and the core is out of reset
    enabled_flag = gate_on_r && !core_reset_r;
  end

  // ****************************************************************
  // Glitch-free source switch and gate
  // ****************************************************************

  // Source changes happen only while both old and new sources are low, so no
  // high phase of the output is ever shortened; costs a few cycles of delay
  always_comb begin
    src_active_nxt = src_active_r;
    gate_on_nxt = gate_on_r;
    if ((baud_source_select_r != src_active_r) && !xtal_sync_r && !div_clk) begin
      src_active_nxt = baud_source_select_r;
    end
    src_level = (src_active_r == scr_pkg::SRC_PLL) ? div_clk : xtal_sync_r;
    if (!src_level && !spi_clk_r) begin
      gate_on_nxt = mode_gate;
    end
    spi_clk_nxt = src_level && gate_on_r;
    core_reset_nxt = core_soft_reset_r;
  end

  // Clock output and core reset come straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_active_r <= scr_pkg::SRC_XTAL;
      gate_on_r <= 1'b0;
      spi_clk_r <= 1'b0;
      core_reset_r <= 1'b0;
    end else if (ce) begin
      src_active_r <= src_active_nxt;
      gate_on_r <= gate_on_nxt;
      spi_clk_r <= spi_clk_nxt;
      core_reset_r <= core_reset_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign spi_clk_out = spi_clk_r;
  assign core_reset_out = core_reset_r;

endmodule

// ### scr_clock_reset_ctrl_chk.sv
/*
  Port checker for the SPI clock and reset slice, bound to its top.
  Assumes pclk is the only clock and presetn the async active-low reset.
*/
`timescale 1ns/1ps

module scr_crc_chk #(
  parameter int PHASE_W = scr_pkg::PHASE_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Mode and outputs
  input wire logic [1:0] power_mode,
  input wire logic spi_clk_out,
  input wire logic core_reset_out
);
  // ****************************************
  // Helpers
  // ****************************************
  logic mapped;
  logic wr_rst;
  logic rd;
  logic [4:0] ds_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decode of the completing transfer
  assign mapped = paddr == 8'h2c || paddr == 8'h30 || paddr == 8'h34;
  assign rd = pready && !pwrite;
  assign wr_rst = pready && pwrite && paddr == scr_pkg::OFS_RST_CTL;
  // Deep-sleep dwell, saturating so it never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ds_r <= 5'h00;
    end else begin
      ds_r <= (power_mode != 2'h2) ? 5'h00 : (ds_r == 5'h14) ? ds_r : ds_r + 5'h01;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  rdy_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  rdy_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  err_unmap_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  cfg_bits_a: assert property (rd && paddr == 8'h2c |-> (prdata & 32'hfffef8f8) == 32'h0)
    else $error("divider unused bits set");
  gate_bits_a: assert property (rd && paddr == 8'h30 |-> (prdata & 32'hfffffefe) == 32'h0)
    else $error("gate register bad bits");
  rst_bits_a: assert property (rd && paddr == 8'h34 |-> prdata[31:2] == 30'h0)
    else $error("reset register unused bits set");
  srst_set_a: assert property (wr_rst && pwdata[0] |-> ##[1:2] core_reset_out)
    else $error("soft reset not asserted");
  srst_clr_a: assert property (wr_rst && !pwdata[0] |-> ##[1:2] !core_reset_out)
    else $error("soft reset not released");
  deep_off_a: assert property (ds_r == 5'h14 |-> !spi_clk_out)
    else $error("clock runs in deep sleep");
endmodule

bind scr_clock_reset_ctrl scr_crc_chk #(.PHASE_W(PHASE_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_mode(power_mode),
  .spi_clk_out(spi_clk_out), .core_reset_out(core_reset_out));

// ### scr_clock_reset_ctrl_tb.sv
/*
  Self-checking bench for the SPI clock and reset slice.
  Assumes the package constants; the bench acts as APB master and crystal.
*/
`timescale 1ns/1ps

module scr_clock_reset_ctrl_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, spi_clk_out, core_reset_out, er, xtal_clk_in = 1'b0;
  logic [1:0] power_mode = 2'h0, xdiv = 2'h0;
  int err_total = 0, total_checks = 0;

  // Clock; crystal stand-in toggles every 3 cycles
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    xdiv <= (xdiv == 2'h2) ? 2'h0 : xdiv + 2'h1;
    if (xdiv == 2'h2) xtal_clk_in <= ~xtal_clk_in;
  end

  scr_clock_reset_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xtal_clk_in(xtal_clk_in), .power_mode(power_mode),
    .spi_clk_out(spi_clk_out), .core_reset_out(core_reset_out));

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer, then an idle cycle so no signal is driven twice per step
  // Waits as long as the slave takes; only the watchdog ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task cfg(input logic [31:0] dv, input logic [31:0] gt, input logic [31:0] sr);
    apb(1'b1, scr_pkg::OFS_DIV_CFG, dv);
    apb(1'b1, scr_pkg::OFS_GATE_EN, gt);
    apb(1'b1, scr_pkg::OFS_RST_CTL, sr);
  endtask

  // Edges seen on the output after a settling span
  task toggles(output int k);
    logic p;
    k = 0;
    repeat (20) @(posedge pclk);
    p = spi_clk_out;
    repeat (40) begin @(posedge pclk); if (spi_clk_out !== p) k++; p = spi_clk_out; end
  endtask

  task phases(output int hi, output int lo);
    int n;
    hi = 0;
    lo = 0;
    n = 0;
    while (spi_clk_out !== 1'b0 && n < 40) begin @(posedge pclk); n++; end
    while (spi_clk_out !== 1'b1 && n < 80) begin @(posedge pclk); n++; end
    while (spi_clk_out === 1'b1 && n < 120) begin @(posedge pclk); n++; hi++; end
    while (spi_clk_out === 1'b0 && n < 160) begin @(posedge pclk); n++; lo++; end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    rchk(scr_pkg::OFS_DIV_CFG, 32'h0);
    rchk(scr_pkg::OFS_GATE_EN, 32'h0);
    rchk(scr_pkg::OFS_RST_CTL, 32'h0);
    chk(32'(core_reset_out), 32'h0);
    $display("t_reset done");
  endtask

  // All ones everywhere; only the writable fields stick
  task t_regs;
    cfg(32'hffffffff, 32'hffffffff, 32'hffffffff);
    rchk(scr_pkg::OFS_DIV_CFG, 32'h00010707);
    rchk(scr_pkg::OFS_GATE_EN, 32'h00000101);
    rchk(scr_pkg::OFS_RST_CTL, 32'h00000001);
    chk(32'(core_reset_out), 32'h1);
    apb(1'b1, 8'h38, 32'hffffffff);
    chk(32'(er), 32'h1);
    rchk(8'h38, 32'h0);
    cfg(32'h0, 32'h0, 32'h0);
    // Core reset follows the register one edge later
    @(posedge pclk);
    chk(32'(core_reset_out), 32'h0);
    $display("t_regs done");
  endtask

  // Divided source, boundary phase codes plus one mid-range pair (high 4, low 2)
  task t_div;
    logic [5:0] tbl [3];
    int hi, lo;
    tbl = '{6'h14, 6'h07, 6'h38};
    power_mode <= 2'h0;
    foreach (tbl[i]) begin
      cfg({15'h0, 1'b1, 5'h0, tbl[i][5:3], 5'h0, tbl[i][2:0]}, 32'h1, 32'h0);
      phases(hi, lo);
      phases(hi, lo);
      chk(hi, 32'(tbl[i][2:0]) + 1);
      chk(lo, 32'(tbl[i][5:3]) + 1);
    end
    $display("t_div done");
  endtask

  // Crystal source across every mode and gate setting
  task t_gate;
    logic [31:0] gt [4];
    int k;
    logic e;
    gt = '{32'h0, 32'h1, 32'h100, 32'h101};
    // Code 3 is not a real mode and must gate off like deep sleep
    for (int m = 0; m < 4; m++) begin
      foreach (gt[g]) begin
        power_mode <= 2'(m);
        cfg(32'h0, gt[g], 32'h0);
        e = (m == 0 && gt[g][0]) || (m == 1 && gt[g][8]);
        toggles(k);
        chk(32'(k > 0), 32'(e));
        rchk(scr_pkg::OFS_RST_CTL, {30'h0, e, 1'b0});
      end
    end
    $display("t_gate done");
  endtask

  // Clock enable low must freeze the output, high must let it run again
  task t_freeze;
    logic p;
    int k;
    power_mode <= 2'h0;
    cfg(32'h0, 32'h1, 32'h0);
    toggles(k);
    chk(32'(k > 0), 32'h1);
    ce <= 1'b0;
    @(posedge pclk);
    p = spi_clk_out;
    k = 0;
    repeat (20) begin @(posedge pclk); if (spi_clk_out !== p) k++; end
    chk(32'(k), 32'h0);
    ce <= 1'b1;
    toggles(k);
    chk(32'(k > 0), 32'h1);
    $display("t_freeze done");
  endtask

  // Reset in mid-run must clear every written field again
  task t_mid_reset;
    cfg(32'hffffffff, 32'hffffffff, 32'hffffffff);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(core_reset_out), 32'h0);
    chk(32'(spi_clk_out), 32'h0);
    rchk(scr_pkg::OFS_DIV_CFG, 32'h0);
    rchk(scr_pkg::OFS_GATE_EN, 32'h0);
    rchk(scr_pkg::OFS_RST_CTL, 32'h0);
    $display("t_mid_reset done");
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Main sequence, reset held two cycles
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_regs;
    t_div;
    t_gate;
    t_freeze;
    t_mid_reset;
    end_of_test;
  end

  // Watchdog, far beyond the few thousand cycles expected
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    end_of_test;
  end
endmodule
